// File: rtl/dcs_map.svh
// Offsets, field positions, reset values and timing counts of the sequencer.
`ifndef DCS_MAP_SVH
`define DCS_MAP_SVH

`define DCS_CLK_MHZ        250
`define DCS_MCLK_PERIOD_US 250
`define DCS_TICK_CYC       (`DCS_CLK_MHZ * `DCS_MCLK_PERIOD_US)
`define DCS_OSC_CYC        8'h10
`define DCS_BCD_MAX        4'h9

`define DCS_REG_CTRL       8'h00
`define DCS_REG_INTERVAL   8'h04
`define DCS_REG_STATUS     8'h08
`define DCS_REG_DIGITS     8'h0C

`define DCS_CTRL_EN        0
`define DCS_CTRL_CONT      1
`define DCS_CTRL_RST_EN    1'b1
`define DCS_CTRL_RST_CONT  1'b0
`define DCS_INTERVAL_RST   16'h0005

`define DCS_ST_PERIOD_LSB  0
`define DCS_ST_MEAS        4
`define DCS_ST_POL         5
`define DCS_ST_ABOVE       6
`define DCS_ST_BCD_LSB     8

`endif

// File: rtl/dcs_pkg.sv
// Types shared by the digit conversion sequencer.
package dcs_pkg;

   typedef enum logic [0:0] {
      DCS_STORE   = 1'b0,
      DCS_MEASURE = 1'b1
   } dcs_mode_t;

   typedef struct packed {
      logic [15:0]      tick;
      logic             half;
      logic [3:0]       sh;
      dcs_mode_t        mode;
      logic             pend;
      logic [15:0]      scnt;
      logic             a1;
      logic             a2;
      logic             a3;
      logic             above;
      logic             p1;
      logic             p2;
      logic             p3;
      logic             pol_in;
      logic [7:0]       osc;
      logic [3:0]       bcd;
      logic [3:0][3:0]  dig;
      logic             pol;
      logic [9:0]       numeral;
      logic [3:0]       anode;
      logic             zero;
      logic             gate_zero;
      logic             gate_pol;
      logic [2:0]       rem;
      logic             ack;
      logic [31:0]      dat;
      logic             en;
      logic             cont;
      logic [15:0]      interval;
   } dcs_state_t;

endpackage : dcs_pkg

// File: rtl/dcs_top.sv
// Digit conversion sequencer: timing, counting, display and Wishbone slave.
//
// Contract
// RULE_01: Timing steps through zero period then four digitizing periods.
// RULE_02: Sample request resynchronises the shift register to the zero period.
// RULE_03: Sample oscillator sets measure or storage mode; gates derive from it.
// RULE_04: Pulse oscillator runs only while the front end reports above threshold.
// RULE_05: Counter counts oscillator pulses in BCD during the digitizing period.
// RULE_06: Counter value drives the ladder switch outputs directly.
// RULE_07: Decoder turns the BCD value into one of ten numeral lines.
// RULE_08: Once counting stops, only the tube of that period is strobed.
// RULE_09: Period A feeds tube one, B tube two, through D tube four.
// RULE_10: Remainder is stored at each period end for the next period.
// RULE_11: Polarity latch holds the captured polarity until displayed.
// RULE_12: Digits captured in measure mode, shown from storage in storage mode.
// RULE_13: Master tick every 250 us; halved to step the shift register.
// RULE_14: Zero period is asserted exactly when no digitizing period is active; zero_o is a flop that follows period_o one clock later.
// RULE_15: Polarity detection enabled only in period A during measure mode.
// RULE_16: Counter is cleared at the start of every digitizing period.
// RULE_17: Counter saturates at nine so no invalid BCD code appears.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`include "dcs_map.svh"

module dcs_top
   import dcs_pkg::*;
#(
   parameter logic [15:0] TICK_CYC = 16'(`DCS_TICK_CYC)
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   input  wire logic        above_i,
   input  wire logic        polarity_i,
   output logic      [3:0]  ladder_o,
   output logic      [9:0]  numeral_o,
   output logic      [3:0]  anode_o,
   output logic      [3:0]  period_o,
   output logic             zero_o,
   output logic             measure_o,
   output logic             gate_zero_o,
   output logic             gate_pol_o,
   output logic      [2:0]  remainder_o,
   output logic             polarity_o
);

   dcs_state_t s_r;
   dcs_state_t s_nxt;

   // Index of the active digitizing period; zero period maps to index 0.
   function automatic logic [1:0] period_idx(input logic [3:0] sh);
      logic [1:0] idx;
      idx = 2'h0;
      if (sh[1]) begin
         idx = 2'h1;
      end
      if (sh[2]) begin
         idx = 2'h2;
      end
      if (sh[3]) begin
         idx = 2'h3;
      end
      return idx;
   endfunction : period_idx

   // One-of-ten decode; codes above nine select no line at all, so a
   // corrupted count darkens the tubes instead of lighting a false digit.
   function automatic logic [9:0] numeral_of(input logic [3:0] v);
      logic [9:0] n;
      n = 10'h000;
      case (v) // see RULE_07
         4'h0: begin
            n = 10'h001;
         end
         4'h1: begin
            n = 10'h002;
         end
         4'h2: begin
            n = 10'h004;
         end
         4'h3: begin
            n = 10'h008;
         end
         4'h4: begin
            n = 10'h010;
         end
         4'h5: begin
            n = 10'h020;
         end
         4'h6: begin
            n = 10'h040;
         end
         4'h7: begin
            n = 10'h080;
         end
         4'h8: begin
            n = 10'h100;
         end
         4'h9: begin
            n = 10'h200;
         end
         default: begin
            n = 10'h000;
         end
      endcase
      return n;
   endfunction : numeral_of

   // Second and third synchroniser stages must agree before a pin change
   // is believed; a single-cycle glitch on the pin is thereby ignored.
   function automatic logic agreed(input logic held,
                                   input logic s2,
                                   input logic s3);
      logic v;
      v = held;
      if (s2 == s3) begin
         v = s3;
      end
      return v;
   endfunction : agreed

   // Saturating BCD step; a digit at nine or above keeps its value.
   function automatic logic [3:0] bcd_sat_inc(input logic [3:0] v);
      logic [3:0] r;
      r = v;
      if (v < `DCS_BCD_MAX) begin // see RULE_17
         r = v + 4'h1; // see RULE_05
      end
      return r;
   endfunction : bcd_sat_inc

   // Last value of the sample interval counter; an interval of zero is
   // treated as one so that the counter never has to wrap to end it.
   function automatic logic [15:0] last_step(input logic [15:0] iv);
      logic [15:0] r;
      r = 16'h0000;
      if (iv != 16'h0000) begin
         r = iv - 16'h0001;
      end
      return r;
   endfunction : last_step

   // Walk of the timing register: the zero period leads into A, then the
   // one-hot bit moves on through B, C and D and falls back to zero.
   function automatic logic [3:0] next_shift(input logic [3:0] sh);
      logic [3:0] r;
      r = {sh[2:0], 1'b0};
      if (sh == 4'h0) begin
         r = 4'h1;
      end
      return r;
   endfunction : next_shift

   logic       tick_end;
   logic       step;
   logic       digit_act;
   logic       meas;
   logic       hit;
   logic [1:0] idx;
   logic [3:0] shown;
   logic [31:0] rd;

   always_comb begin
      s_nxt     = s_r;
      meas      = (s_r.mode == DCS_MEASURE);
      idx       = period_idx(s_r.sh);
      digit_act = |s_r.sh;
      tick_end  = (s_r.tick == TICK_CYC - 16'h0001);
      step      = tick_end && s_r.half;
      hit       = cyc_i && stb_i && !s_r.ack;

      // Pin inputs pass three flops; a change counts once two and three agree.
      s_nxt.a1 = above_i;
      s_nxt.a2 = s_r.a1;
      s_nxt.a3 = s_r.a2;
      s_nxt.above = agreed(s_r.above, s_r.a2, s_r.a3);
      s_nxt.p1 = polarity_i;
      s_nxt.p2 = s_r.p1;
      s_nxt.p3 = s_r.p2;
      s_nxt.pol_in = agreed(s_r.pol_in, s_r.p2, s_r.p3);

      // Master tick and the divide-by-two that clocks the shift register.
      s_nxt.tick = tick_end ? 16'h0000 : s_r.tick + 16'h0001; // see RULE_13
      if (tick_end) begin
         s_nxt.half = !s_r.half; // see RULE_13
      end

      s_nxt.rem = 3'h0;
      if (step) begin
         if (!s_r.en) begin
            s_nxt.sh   = 4'h0;
            s_nxt.mode = DCS_STORE;
         end else if (s_r.pend) begin
            // Restart aligned to the master clock at the zero period.
            s_nxt.sh   = 4'h0; // see RULE_02
            s_nxt.mode = DCS_MEASURE; // see RULE_03
            s_nxt.pend = 1'b0;
         end else begin
            s_nxt.sh = next_shift(s_r.sh); // see RULE_01
            if (s_r.sh[3] && !s_r.cont) begin
               s_nxt.mode = DCS_STORE; // see RULE_03
            end
         end
         // Sample interval counted in shift register steps. It sits after
         // the restart so that a request raised on the same step is kept.
         if (s_r.scnt >= last_step(s_r.interval)) begin
            s_nxt.scnt = 16'h0000;
            s_nxt.pend = s_r.en; // see RULE_03
         end else begin
            s_nxt.scnt = s_r.scnt + 16'h0001;
         end
         if (digit_act && meas) begin
            s_nxt.dig[idx] = s_r.bcd; // see RULE_12
            if (!s_r.sh[3]) begin
               // No remainder is kept after the last digit.
               s_nxt.rem[idx] = 1'b1; // see RULE_10
            end
         end
         s_nxt.bcd = 4'h0; // see RULE_16
         s_nxt.osc = 8'h00;
      end else begin
         // Oscillator halts as soon as the front end drops below threshold.
         // The synchroniser delay is far shorter than one oscillator period,
         // so the count cannot run past the digit the front end asks for.
         if (s_r.above && digit_act && meas) begin // see RULE_04
            if (s_r.osc == `DCS_OSC_CYC - 8'h01) begin
               s_nxt.osc = 8'h00;
               s_nxt.bcd = bcd_sat_inc(s_r.bcd); // see RULE_05
            end else begin
               s_nxt.osc = s_r.osc + 8'h01;
            end
         end else begin
            s_nxt.osc = 8'h00; // see RULE_04
         end
      end

      // Gating pulses derived from the mode and the period.
      s_nxt.zero      = !(|s_r.sh); // see RULE_14
      s_nxt.gate_zero = !digit_act && meas; // see RULE_03
      s_nxt.gate_pol  = s_r.sh[0] && meas; // see RULE_15
      if (s_r.sh[0] && meas) begin
         s_nxt.pol = s_r.pol_in; // see RULE_11
      end

      // Measure shows the live count once it stops; storage replays digits.
      s_nxt.anode = 4'h0;
      shown       = s_r.dig[idx];
      if (meas) begin
         shown = s_r.bcd;
         if (!s_r.above) begin
            s_nxt.anode = s_r.sh; // see RULE_08
         end
      end else begin
         s_nxt.anode = s_r.sh; // see RULE_09
      end
      s_nxt.numeral = numeral_of(shown); // see RULE_12

      // Wishbone classic slave: ack one cycle after the strobe, one cycle wide.
      rd = 32'h0000_0000;
      case (adr_i)
         `DCS_REG_CTRL: begin
            rd[`DCS_CTRL_EN]   = s_r.en;
            rd[`DCS_CTRL_CONT] = s_r.cont;
         end
         `DCS_REG_INTERVAL: begin
            rd[15:0] = s_r.interval;
         end
         `DCS_REG_STATUS: begin
            rd[`DCS_ST_PERIOD_LSB +: 4] = s_r.sh;
            rd[`DCS_ST_MEAS]            = meas;
            rd[`DCS_ST_POL]             = s_r.pol;
            rd[`DCS_ST_ABOVE]           = s_r.above;
            rd[`DCS_ST_BCD_LSB +: 4]    = s_r.bcd;
         end
         `DCS_REG_DIGITS: begin
            rd[15:0] = s_r.dig;
         end
         default: begin
            rd = 32'h0000_0000;
         end
      endcase
      s_nxt.ack = hit;
      if (hit) begin
         s_nxt.dat = rd;
         if (we_i && adr_i == `DCS_REG_CTRL && sel_i[0]) begin
            s_nxt.en   = dat_i[`DCS_CTRL_EN];
            s_nxt.cont = dat_i[`DCS_CTRL_CONT];
         end
         if (we_i && adr_i == `DCS_REG_INTERVAL) begin
            if (sel_i[0]) begin
               s_nxt.interval[7:0] = dat_i[7:0];
            end
            if (sel_i[1]) begin
               s_nxt.interval[15:8] = dat_i[15:8];
            end
         end
      end
   end

   // Reset leaves storage mode with the zero period showing; until the first
   // sample request has been served the tubes replay the cleared digits as zero.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r          <= '0;
         s_r.mode     <= DCS_STORE;
         s_r.zero     <= 1'b1;
         s_r.en       <= `DCS_CTRL_RST_EN;
         s_r.cont     <= `DCS_CTRL_RST_CONT;
         s_r.interval <= `DCS_INTERVAL_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Every output is a flop of the state record; no gate reaches a pin,
   // which keeps the tube drivers free of decode glitches.
   assign dat_o       = s_r.dat;
   assign ack_o       = s_r.ack;
   assign ladder_o    = s_r.bcd; // see RULE_06
   assign numeral_o   = s_r.numeral;
   assign anode_o     = s_r.anode;
   assign period_o    = s_r.sh;
   assign zero_o      = s_r.zero;
   assign measure_o   = s_r.mode;
   assign gate_zero_o = s_r.gate_zero;
   assign gate_pol_o  = s_r.gate_pol;
   assign remainder_o = s_r.rem;
   assign polarity_o  = s_r.pol;

endmodule : dcs_top

// File: verif/dcs_top_monitor.sv
// Port-level checks of the sequencer's timing, counting and display outputs.
`timescale 1ns/1ps
module dcs_top_monitor (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [3:0] ladder_o,
   input wire logic [9:0] numeral_o,
   input wire logic [3:0] anode_o,
   input wire logic [3:0] period_o,
   input wire logic       zero_o,
   input wire logic       measure_o,
   input wire logic       gate_zero_o,
   input wire logic       gate_pol_o,
   input wire logic [2:0] remainder_o,
   input wire logic       polarity_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_period_onehot:
      assert property ($onehot0(period_o)) else $error("period not one-hot");
   chk_zero_match:
      assert property (zero_o == ($past(period_o) == 4'h0))
      else $error("zero flag wrong");
   chk_numeral_valid:
      assert property ($onehot0(numeral_o) && ladder_o <= 4'h9)
      else $error("bad numeral or count");
   chk_numeral_track:
      assert property ($past(measure_o) |->
         numeral_o == (10'h001 << $past(ladder_o)))
      else $error("numeral line wrong");
   chk_count_step:
      assert property ($changed(ladder_o) |->
         ladder_o == $past(ladder_o) + 4'h1 || ladder_o == 4'h0)
      else $error("count jumped");
   chk_count_gap:
      assert property ($changed(ladder_o) && ladder_o != 4'h0 |=>
         !(ladder_o > $past(ladder_o)) [*8]) else $error("count too fast");
   chk_anode_tube:
      assert property (anode_o != 4'h0 && measure_o |->
         anode_o == period_o || anode_o == $past(period_o))
      else $error("wrong tube strobed");
   chk_remainder_pulse:
      assert property (remainder_o != 3'h0 |->
         $onehot(remainder_o) && measure_o ##1 remainder_o == 3'h0)
      else $error("bad remainder pulse");
   chk_pol_gate:
      assert property (gate_pol_o |->
         measure_o && (period_o[0] || $past(period_o[0])))
      else $error("polarity gate outside A");
   chk_zero_gate:
      assert property (gate_zero_o |-> (zero_o || period_o == 4'h0) &&
         (measure_o || $past(measure_o))) else $error("zero gate wrong");
   chk_pol_hold:
      assert property ($changed(polarity_o) |-> gate_pol_o || $past(gate_pol_o))
      else $error("polarity changed");
endmodule : dcs_top_monitor

bind dcs_top dcs_top_monitor chk_u (.clk_i(clk_i), .rst_i(rst_i),
   .ladder_o(ladder_o), .numeral_o(numeral_o), .anode_o(anode_o),
   .period_o(period_o), .zero_o(zero_o), .measure_o(measure_o),
   .gate_zero_o(gate_zero_o), .gate_pol_o(gate_pol_o),
   .remainder_o(remainder_o), .polarity_o(polarity_o));

// File: verif/dcs_front_model.sv
// Behavioural front end: above threshold until the ladder reaches the digit.
`timescale 1ns/1ps
module dcs_front_model (
   input  wire logic        clk_i,
   input  wire logic [3:0]  ladder_i,
   input  wire logic [3:0]  period_i,
   input  wire logic [15:0] digits_i,
   output logic             above_o = 1'b0
);
   int k;
   // A digit above nine keeps the front end high, as an overrange input would.
   always @(posedge clk_i) begin
      above_o <= 1'b0;
      for (k = 0; k < 4; k++)
         if (period_i[k] && ladder_i < digits_i[4*k +: 4])
            above_o <= 1'b1;
   end
endmodule : dcs_front_model

// File: verif/tb_top.sv
// Self-checking bench of the sequencer with a front-end model.
`timescale 1ns/1ps
module tb_top;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic        pol = 1'b0, above, ack, zero, meas, gz, gp, pol_o;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hF, ladder, anode, period;
   logic [31:0] dat = 32'h0, rdat;
   logic [15:0] digits = 16'h0;
   logic [9:0]  numeral;
   logic [2:0]  rem;
   logic [31:0] expq[$];
   int          mismatches = 0, tests_run = 0, i;

   always #2 clk_i = ~clk_i;

   dcs_top #(.TICK_CYC(16'h0080)) dut_u (.clk_i(clk_i), .rst_i(rst_i),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
      .dat_i(dat), .dat_o(rdat), .ack_o(ack), .above_i(above),
      .polarity_i(pol), .ladder_o(ladder), .numeral_o(numeral),
      .anode_o(anode), .period_o(period), .zero_o(zero), .measure_o(meas),
      .gate_zero_o(gz), .gate_pol_o(gp), .remainder_o(rem),
      .polarity_o(pol_o));
   dcs_front_model fe_u (.clk_i(clk_i), .ladder_i(ladder), .period_i(period),
      .digits_i(digits), .above_o(above));

   task automatic check_word(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask : check_word

   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, e);
      @(posedge clk_i);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d;
      if (!w) expq.push_back(e);
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      cyc <= 1'b0; stb <= 1'b0;
   endtask : wb

   // Reads are scored when the slave answers, not when they are issued.
   always @(posedge clk_i)
      if (ack === 1'b1 && we === 1'b0)
         check_word("rdata", expq.pop_front(), rdat);

   task automatic wait_meas();
      while (meas !== 1'b1) @(posedge clk_i);
      while (meas !== 1'b0) @(posedge clk_i);
   endtask : wait_meas

   task automatic stop_test();
      if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   initial begin
      void'($urandom(32'h7F69E2E4));
      for (i = 0; i < 4; i++) digits[4*i +: 4] = 4'($urandom % 10);
      pol = 1'($urandom);
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, 8'h00, 32'h0, 32'h1);
      wb(1'b0, 8'h04, 32'h0, 32'h5);
      wb(1'b1, 8'h04, 32'h7, 32'h0);
      wb(1'b0, 8'h04, 32'h0, 32'h7);
      wb(1'b0, 8'h10, 32'h0, 32'h0);
      wait_meas();
      wb(1'b0, 8'h0C, 32'h0, {16'h0, digits});
      check_word("polarity", {31'h0, pol}, {31'h0, pol_o});
      digits <= 16'hFFFF;
      wait_meas();
      wb(1'b0, 8'h0C, 32'h0, 32'h9999);
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      stop_test();
   end
endmodule : tb_top
